// >>> btc_pkg.sv
// ****************************************************************
// Operation
// (RULE_01) Counters advance from the 32-kHz time base
// (RULE_02) Seconds, minutes, hours held as two BCD digits
// (RULE_03) Calendar held in BCD, correct through 2099
// (RULE_04) Year counts 00 to 99
// (RULE_05) Year multiple of four is leap year
// (RULE_06) Month 01 to 12, wraps, bumps year
// (RULE_07) Day limit 31 or 30 by month
// (RULE_08) February ends at 29 leap, 28 common
// (RULE_09) Weekday 0 to 6, steps with day
// (RULE_10) Hours 0-23, or 1-12 with meridiem flag
// (RULE_11) Minutes and seconds 0-59 with carry
// (RULE_12) Software writes only legal BCD values
// (RULE_13) Round-to-minute applied at next seconds tick
// (RULE_14) Round up from 30 s, else clear
// (RULE_15) Hardware clears round bit when done
// (RULE_16) Periodic tick: second, minute, hour or day
// (RULE_17) Periodic tick may be held during sleep
// (RULE_18) Alarm fires when time equals alarm
// (RULE_19) Calibration resolution one 32768th second
// (RULE_20) Held tick delivered on leaving sleep
// (RULE_21) Hourly second 1-2 length minus compensation
// (RULE_22) Snapshot copies time into coherent shadow
// (RULE_23) Second tick every 32768 base cycles
// (RULE_24) 11 to 12 toggles meridiem; 12 to 1 not
// ****************************************************************
package btc_pkg;
  // Bus geometry
  localparam int AW = 8;
  localparam int DW = 32;
  // Register byte offsets
  localparam logic [7:0] OFS_TC_LAST = 8'h18;
  localparam logic [7:0] OFS_AL_FIRST = 8'h20;
  localparam logic [7:0] OFS_AL_LAST = 8'h34;
  localparam logic [7:0] OFS_CTRL = 8'h40;
  localparam logic [7:0] OFS_STAT = 8'h44;
  localparam logic [7:0] OFS_IRQC = 8'h48;
  localparam logic [7:0] OFS_COMP = 8'h4C;
  // Time and calendar slot indexes
  localparam logic [2:0] IX_SEC = 3'h0;
  localparam logic [2:0] IX_MIN = 3'h1;
  localparam logic [2:0] IX_HOUR = 3'h2;
  localparam logic [2:0] IX_DAY = 3'h3;
  localparam logic [2:0] IX_MON = 3'h4;
  localparam logic [2:0] IX_YEAR = 3'h5;
  localparam logic [2:0] IX_WEEK = 3'h6;
  localparam int HOUR_PM = 7;
  // Control fields
  localparam int CTRL_RUN = 0;
  localparam int CTRL_ROUND = 1;
  localparam int CTRL_MER = 2;
  localparam int CTRL_SNAP = 3;
  localparam int CTRL_COMP = 4;
  localparam logic [4:0] CTRL_RST = 5'h01;
  // Interrupt control fields
  localparam int IRQC_PER = 0;
  localparam int IRQC_TICK = 2;
  localparam int IRQC_ALARM = 3;
  localparam int IRQC_HOLD = 4;
  localparam logic [4:0] IRQC_RST = 5'h00;
  // Reset values of the calendar
  localparam logic [7:0] DAY_RST = 8'h01;
  localparam logic [7:0] MON_RST = 8'h01;
  // BCD limits
  localparam logic [7:0] BCD_00 = 8'h00;
  localparam logic [7:0] BCD_01 = 8'h01;
  localparam logic [7:0] BCD_06 = 8'h06;
  localparam logic [7:0] BCD_11 = 8'h11;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_28 = 8'h28;
  localparam logic [7:0] BCD_29 = 8'h29;
  localparam logic [7:0] BCD_30 = 8'h30;
  localparam logic [7:0] BCD_31 = 8'h31;
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_99 = 8'h99;
  // Base cycles per second
  localparam int SEC_CYCLES = 32768;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // Periodic tick period
  typedef enum logic [1:0] {
    BTC_PER_SEC = 2'b00,
    BTC_PER_MIN = 2'b01,
    BTC_PER_HOUR = 2'b10,
    BTC_PER_DAY = 2'b11
  } btc_period_t;
endpackage

// >>> btc_bcd_step.sv
`timescale 1ns/1ps
// ****************************************************************
// Two-digit BCD increment with wrap
// ****************************************************************
module btc_bcd_step (
  // Current value and range
  input wire logic [7:0] val,
  input wire logic [7:0] lo,
  input wire logic [7:0] hi,
  // Stepped value and wrap flag
  output logic [7:0] nxt,
  output logic wrap
);
  // At or beyond the top wraps, so a bad value recovers
  always_comb begin
    wrap = (val >= hi);
    if (wrap) begin
      nxt = lo;
    end else if (val[3:0] >= 4'h9) begin
      nxt = {val[7:4] + 4'h1, 4'h0};
    end else begin
      nxt = {val[7:4], val[3:0] + 4'h1};
    end
  end
endmodule

// >>> btc_presc.sv
`timescale 1ns/1ps
// ****************************************************************
// Seconds prescaler with hourly compensation
// ****************************************************************
module btc_presc #(
  parameter int SEC_CNT = btc_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Time base
  input wire logic tick32,
  input wire logic run,
  // Compensation
  input wire logic adj,
  input wire logic [15:0] comp,
  // Seconds strobe
  output logic sec_tick
);
  logic [16:0] cnt;
  logic [16:0] next_cnt;
  logic next_sec_tick;
  logic [17:0] lim_full;
  logic [16:0] lim;

  // Interval end: shorten or lengthen by the signed value
  always_comb begin
    lim_full = 18'(SEC_CNT - 1);
    if (adj) begin
      lim_full = 18'(SEC_CNT - 1) - {{2{comp[15]}}, comp}; // RULE_21 RULE_19
    end
    lim = lim_full[16:0];
  end

  // Count base edges; a second ends at the limit
  always_comb begin
    next_cnt = cnt;
    next_sec_tick = 1'b0;
    if (run && tick32) begin
      if (cnt >= lim) begin
        next_cnt = 17'h0_0000;
        next_sec_tick = 1'b1; // RULE_01 RULE_23
      end else begin
        next_cnt = cnt + 17'h0_0001;
      end
    end
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cnt <= 17'h0_0000;
      sec_tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      sec_tick <= next_sec_tick;
    end
  end

  a_tick_at_lim: assert property (@(posedge mclk) disable iff (!rstn) // RULE_23
    run && tick32 && cnt == lim |=> sec_tick)
    else $error("Second tick missing at count limit");
  a_plain_len: assert property (@(posedge mclk) disable iff (!rstn) // RULE_23
    !adj |-> lim == 17'(SEC_CNT - 1))
    else $error("Plain second length is wrong");
endmodule

// >>> btc_top.sv
`timescale 1ns/1ps
// ****************************************************************
// Time and calendar core with AXI4-Lite registers
// ****************************************************************
module btc_top #(
  parameter int SEC_CNT = btc_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Time base and power state
  input wire logic tick32,
  input wire logic sleep,
  // AXI4-Lite write channels
  input wire logic [btc_pkg::AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [btc_pkg::DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [btc_pkg::AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [btc_pkg::DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt lines
  output logic periodic_tick_irq,
  output logic alarm_match_irq
);
  import btc_pkg::*;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [7:0] tc [7];
  logic [7:0] shadow [7];
  logic [7:0] alarm [6];
  logic [4:0] ctrl;
  logic [4:0] irqc;
  logic [15:0] comp;
  logic pend;
  logic tick_d;
  logic [7:0] next_tc [7];
  logic [7:0] next_shadow [7];
  logic [7:0] next_alarm [6];
  logic [4:0] next_ctrl;
  logic [4:0] next_irqc;
  logic [15:0] next_comp;
  logic next_pend;
  logic next_tick_irq;
  logic next_alarm_irq;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic aw_hold;
  logic w_hold;
  logic [AW-1:0] aw_q;
  logic [DW-1:0] w_q;
  logic [3:0] s_q;
  logic next_aw_hold;
  logic next_w_hold;
  logic [AW-1:0] next_aw_q;
  logic [DW-1:0] next_w_q;
  logic [3:0] next_s_q;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [DW-1:0] next_rdata;
  logic [1:0] next_rresp;
  logic [DW-1:0] rd_word;
  logic wr_fire;

  // Word-aligned mapped offsets
  function automatic logic addr_ok(input logic [AW-1:0] a);
    addr_ok = (a[1:0] == 2'b00) && ((a <= OFS_TC_LAST)
      || (a >= OFS_AL_FIRST && a <= OFS_AL_LAST) || a == OFS_CTRL
      || a == OFS_STAT || a == OFS_IRQC || a == OFS_COMP);
  endfunction

  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;

  // Read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    if (!addr_ok(s_axi_araddr)) begin
      rd_word = 32'h0000_0000;
    end else if (s_axi_araddr <= OFS_TC_LAST) begin
      rd_word[7:0] = ctrl[CTRL_SNAP] ? shadow[s_axi_araddr[4:2]]
        : tc[s_axi_araddr[4:2]]; // RULE_22
    end else if (s_axi_araddr <= OFS_AL_LAST) begin
      rd_word[7:0] = alarm[s_axi_araddr[4:2]];
    end else if (s_axi_araddr == OFS_CTRL) begin
      rd_word[4:0] = ctrl;
    end else if (s_axi_araddr == OFS_STAT) begin
      rd_word[1:0] = {pend, ctrl[CTRL_RUN]};
    end else if (s_axi_araddr == OFS_IRQC) begin
      rd_word[4:0] = irqc;
    end else begin
      rd_word[15:0] = comp;
    end
  end

  // Channel handshakes
  always_comb begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_q = aw_q;
    next_w_q = w_q;
    next_s_q = s_q;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_q = s_axi_wdata;
      next_s_q = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = addr_ok(aw_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    next_awready = !next_aw_hold;
    next_wready = !next_w_hold;
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rdata = rd_word;
      next_rresp = addr_ok(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end else if (!s_axi_rvalid) begin
      next_arready = 1'b1;
    end
  end

  // Bus registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      s_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_q <= next_aw_q;
      w_q <= next_w_q;
      s_q <= next_s_q;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ****************************************************************
  // Time base and counting chain
  // ****************************************************************
  logic sec_tick;
  logic adj;
  logic rnd;
  logic leap;
  logic mer;
  logic hour_pm;
  logic [7:0] hour;
  logic [7:0] day_max;
  logic [7:0] nx_sec, nx_min, nx_hour, nx_day, nx_mon, nx_year, nx_week;
  logic w_sec, w_min, w_h24, w_day, w_mon, w_year, w_week;
  logic w_hour;
  logic c_min, c_hr, c_day, c_mon, c_yr;
  logic per_ev;
  logic alarm_eq;

  assign rnd = ctrl[CTRL_ROUND];
  assign mer = ctrl[CTRL_MER];
  assign hour_pm = tc[IX_HOUR][HOUR_PM];
  assign hour = {2'b00, tc[IX_HOUR][5:0]};
  // Compensated interval is second 1 to 2 of each hour
  assign adj = ctrl[CTRL_COMP] && tc[IX_SEC] == BCD_01 && tc[IX_MIN] == BCD_00; // RULE_21

  btc_presc #(.SEC_CNT(SEC_CNT)) u_presc (
    .mclk(mclk),
    .rstn(rstn),
    .tick32(tick32),
    .run(ctrl[CTRL_RUN]),
    .adj(adj),
    .comp(comp),
    .sec_tick(sec_tick)
  );

  // Month length, leap years from the two year digits
  always_comb begin
    leap = tc[IX_YEAR][4] ? (tc[IX_YEAR][3:0] == 4'h2 || tc[IX_YEAR][3:0] == 4'h6)
      : (tc[IX_YEAR][3:0] == 4'h0 || tc[IX_YEAR][3:0] == 4'h4
      || tc[IX_YEAR][3:0] == 4'h8); // RULE_05
    if (tc[IX_MON] == 8'h02) begin
      day_max = leap ? BCD_29 : BCD_28; // RULE_08
    end else if (tc[IX_MON] == 8'h04 || tc[IX_MON] == 8'h06
        || tc[IX_MON] == 8'h09 || tc[IX_MON] == BCD_11) begin
      day_max = BCD_30; // RULE_07
    end else begin
      day_max = BCD_31; // RULE_07
    end
  end

  // BCD digit steppers
  btc_bcd_step u_sec (.val(tc[IX_SEC]), .lo(BCD_00), .hi(BCD_59), .nxt(nx_sec), .wrap(w_sec));
  btc_bcd_step u_min (.val(tc[IX_MIN]), .lo(BCD_00), .hi(BCD_59), .nxt(nx_min), .wrap(w_min));
  btc_bcd_step u_hour (.val(hour), .lo(BCD_00), .hi(BCD_23), .nxt(nx_hour), .wrap(w_h24));
  btc_bcd_step u_day (.val(tc[IX_DAY]), .lo(BCD_01), .hi(day_max), .nxt(nx_day), .wrap(w_day));
  btc_bcd_step u_mon (.val(tc[IX_MON]), .lo(BCD_01), .hi(BCD_12), .nxt(nx_mon), .wrap(w_mon));
  btc_bcd_step u_year (.val(tc[IX_YEAR]), .lo(BCD_00), .hi(BCD_99), .nxt(nx_year), .wrap(w_year));
  btc_bcd_step u_week (.val(tc[IX_WEEK]), .lo(BCD_00), .hi(BCD_06), .nxt(nx_week), .wrap(w_week));

  // Carry chain; rounding forces the minute carry from 30 s
  always_comb begin
    w_hour = mer ? (hour == BCD_11 && hour_pm) : w_h24; // RULE_10
    c_min = sec_tick && (rnd ? (tc[IX_SEC] >= BCD_30) : w_sec); // RULE_11 RULE_14
    c_hr = c_min && w_min; // RULE_11
    c_day = c_hr && w_hour;
    c_mon = c_day && w_day;
    c_yr = c_mon && w_mon; // RULE_06
  end

  // Next time, calendar and register values
  always_comb begin
    next_tc = tc;
    next_shadow = shadow;
    next_alarm = alarm;
    next_ctrl = ctrl;
    next_irqc = irqc;
    next_comp = comp;
    if (sec_tick) begin
      next_tc[IX_SEC] = rnd ? BCD_00 : nx_sec; // RULE_02 RULE_13 RULE_14
      next_ctrl[CTRL_ROUND] = 1'b0; // RULE_15
    end
    if (c_min) begin
      next_tc[IX_MIN] = nx_min;
    end
    if (c_hr) begin
      if (!mer) begin
        next_tc[IX_HOUR] = nx_hour; // RULE_10
      end else if (hour == BCD_12) begin
        next_tc[IX_HOUR] = {hour_pm, 1'b0, BCD_01[5:0]}; // RULE_24
      end else if (hour == BCD_11) begin
        next_tc[IX_HOUR] = {!hour_pm, 1'b0, BCD_12[5:0]}; // RULE_24
      end else begin
        next_tc[IX_HOUR] = {hour_pm, 1'b0, nx_hour[5:0]};
      end
    end
    if (c_day) begin
      next_tc[IX_DAY] = nx_day; // RULE_03 RULE_07 RULE_08
      next_tc[IX_WEEK] = nx_week; // RULE_09
    end
    if (c_mon) begin
      next_tc[IX_MON] = nx_mon; // RULE_06
    end
    if (c_yr) begin
      next_tc[IX_YEAR] = nx_year; // RULE_04
    end
    // Software write wins over a same-cycle hardware update
    if (wr_fire && addr_ok(aw_q) && s_q[0]) begin
      if (aw_q <= OFS_TC_LAST) begin
        next_tc[aw_q[4:2]] = w_q[7:0];
      end else if (aw_q <= OFS_AL_LAST) begin
        next_alarm[aw_q[4:2]] = w_q[7:0];
      end else if (aw_q == OFS_CTRL) begin
        next_ctrl = w_q[4:0];
        if (w_q[CTRL_SNAP]) begin
          next_shadow = tc; // RULE_22
        end
      end else if (aw_q == OFS_IRQC) begin
        next_irqc = w_q[4:0];
      end else if (aw_q == OFS_COMP) begin
        next_comp[7:0] = w_q[7:0];
      end
    end
    if (wr_fire && aw_q == OFS_COMP && s_q[1]) begin
      next_comp[15:8] = w_q[15:8];
    end
  end

  // ****************************************************************
  // Periodic tick and alarm events
  // ****************************************************************
  always_comb begin
    case (btc_period_t'(irqc[IRQC_PER +: 2]))
      BTC_PER_SEC: per_ev = sec_tick; // RULE_16
      BTC_PER_MIN: per_ev = c_min;
      BTC_PER_HOUR: per_ev = c_hr;
      BTC_PER_DAY: per_ev = c_day;
      default: per_ev = 1'b0;
    endcase
    alarm_eq = tc[IX_SEC] == alarm[IX_SEC] && tc[IX_MIN] == alarm[IX_MIN]
      && tc[IX_HOUR] == alarm[IX_HOUR] && tc[IX_DAY] == alarm[IX_DAY]
      && tc[IX_MON] == alarm[IX_MON] && tc[IX_YEAR] == alarm[IX_YEAR];
  end

  // Held ticks wait for sleep to end; a new event sets pending only in sleep with hold on
  always_comb begin
    next_pend = pend;
    next_tick_irq = 1'b0;
    if (pend && !sleep) begin
      next_pend = 1'b0;
      next_tick_irq = 1'b1; // RULE_20
    end
    if (irqc[IRQC_TICK] && per_ev) begin
      if (sleep && irqc[IRQC_HOLD]) begin
        next_pend = 1'b1; // RULE_17
      end else begin
        next_tick_irq = 1'b1; // RULE_16
      end
    end
    next_alarm_irq = tick_d && irqc[IRQC_ALARM] && alarm_eq; // RULE_18
  end

  // Time and event registers
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tc <= '{BCD_00, BCD_00, BCD_00, DAY_RST, MON_RST, BCD_00, BCD_00};
      shadow <= '{default: BCD_00};
      alarm <= '{default: BCD_00};
      ctrl <= CTRL_RST;
      irqc <= IRQC_RST;
      comp <= 16'h0000;
      pend <= 1'b0;
      tick_d <= 1'b0;
      periodic_tick_irq <= 1'b0;
      alarm_match_irq <= 1'b0;
    end else begin
      tc <= next_tc;
      shadow <= next_shadow;
      alarm <= next_alarm;
      ctrl <= next_ctrl;
      irqc <= next_irqc;
      comp <= next_comp;
      pend <= next_pend;
      tick_d <= sec_tick;
      periodic_tick_irq <= next_tick_irq;
      alarm_match_irq <= next_alarm_irq;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_sec_wrap: assert property ( // RULE_11
    sec_tick && !rnd && tc[IX_SEC] == BCD_59 && !wr_fire |=> tc[IX_SEC] == BCD_00)
    else $error("Seconds did not wrap");
  a_min_carry: assert property ( // RULE_11
    c_min && tc[IX_MIN] == BCD_59 && !wr_fire |=> tc[IX_MIN] == BCD_00)
    else $error("Minutes did not wrap");
  a_feb_leap: assert property ( // RULE_08
    c_day && tc[IX_MON] == 8'h02 && tc[IX_DAY] == BCD_29 && !wr_fire
    |=> tc[IX_DAY] == BCD_01 && tc[IX_MON] == 8'h03)
    else $error("Leap February did not end at 29");
  a_feb_common: assert property ( // RULE_08 RULE_05
    c_day && tc[IX_MON] == 8'h02 && tc[IX_YEAR] == BCD_01 && tc[IX_DAY] == BCD_28
    && !wr_fire |=> tc[IX_DAY] == BCD_01)
    else $error("Common February did not end at 28");
  a_year_wrap: assert property ( // RULE_04 RULE_06
    c_yr && tc[IX_YEAR] == BCD_99 && !wr_fire
    |=> tc[IX_YEAR] == BCD_00 && tc[IX_MON] == BCD_01)
    else $error("Year or month did not wrap");
  a_week_wrap: assert property ( // RULE_09
    c_day && tc[IX_WEEK] == BCD_06 && !wr_fire |=> tc[IX_WEEK] == BCD_00)
    else $error("Weekday did not wrap");
  a_hour_mer: assert property ( // RULE_24
    c_hr && mer && hour == BCD_11 && !wr_fire
    |=> tc[IX_HOUR][5:0] == 6'h12 && hour_pm != $past(hour_pm))
    else $error("Meridiem not toggled at 12");
  a_round_up: assert property ( // RULE_14 RULE_15
    sec_tick && rnd && tc[IX_SEC] >= BCD_30 && !wr_fire
    |=> tc[IX_SEC] == BCD_00 && !rnd && tc[IX_MIN] != $past(tc[IX_MIN]))
    else $error("Round up failed");
  a_tick_irq: assert property ( // RULE_16
    per_ev && irqc[IRQC_TICK] && !(sleep && irqc[IRQC_HOLD]) |=> periodic_tick_irq)
    else $error("Periodic tick not raised");
  a_sleep_hold: assert property ( // RULE_17
    per_ev && irqc[IRQC_TICK] && sleep && irqc[IRQC_HOLD] && !pend
    |=> pend && !periodic_tick_irq)
    else $error("Tick not held in sleep");
  a_pend_out: assert property ( // RULE_20
    pend && !sleep |=> periodic_tick_irq && !pend)
    else $error("Held tick not delivered");
  a_alarm_hit: assert property ( // RULE_18
    tick_d && irqc[IRQC_ALARM] && alarm_eq |=> alarm_match_irq)
    else $error("Alarm not raised");
  a_snap_copy: assert property ( // RULE_22
    wr_fire && aw_q == OFS_CTRL && s_q[0] && w_q[CTRL_SNAP]
    |=> shadow[IX_SEC] == $past(tc[IX_SEC]) && shadow[IX_MIN] == $past(tc[IX_MIN]))
    else $error("Snapshot not taken");
  c_round: cover property (sec_tick && rnd);
  c_pend: cover property (pend && !sleep);
  c_alarm: cover property (alarm_match_irq);
  c_year: cover property (c_yr);
endmodule

// >>> bcd_time_calendar_bench.sv
`timescale 1ns/1ps
module bcd_time_calendar_bench;
  import btc_pkg::*;
  // ****************************************************************
  // Bench signals and step table
  // ****************************************************************
  logic mclk = '0, rstn = '0, tick32 = '0, sleep = '0;
  logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DW-1:0] s_axi_wdata = '0, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic periodic_tick_irq, alarm_match_irq;
  int n_mismatch = 0, checks = 0, cyc = 0, np = 0, na = 0, tl = 0, tp = 0, i;
  // Start time and expected time, {year, month, day, hour, min, sec}
  logic [47:0] tt [8] = '{48'h0402_2823_5959, 48'h0302_2823_5959, 48'h9912_3123_5959,
    48'h1004_3023_5959, 48'h0101_0110_5945, 48'h0101_0110_5929, 48'h0101_0111_5959,
    48'h0101_0192_5959};
  logic [47:0] ee [8] = '{48'h0402_2900_0000, 48'h0303_0100_0000, 48'h0001_0100_0000,
    48'h1005_0100_0000, 48'h0101_0111_0000, 48'h0101_0110_5900, 48'h0101_0192_0000,
    48'h0101_0181_0000};
  logic [7:0] cc [8] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h03, 8'h03, 8'h05, 8'h05};
  logic [7:0] ww [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h06, 8'h06, 8'h06, 8'h06};

  btc_top #(.SEC_CNT(8)) DUT (.mclk, .rstn, .tick32, .sleep, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .periodic_tick_irq, .alarm_match_irq);

  // Clock, base strobe every second cycle
  always #5 mclk = ~mclk;
  always @(posedge mclk) tick32 <= ~tick32;
  // Interrupt pulse counters and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    // Count periodic pulses and keep the spacing of the last two
    if (periodic_tick_irq === 1'b1) begin
      np <= np + 1;
      tl <= cyc;
      tp <= cyc - tl;
    end
    if (alarm_match_irq === 1'b1) na <= na + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      finish_test();
    end
  end

  // ****************************************************************
  // Bus tasks and comparison
  // ****************************************************************
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid || s_axi_wvalid);
    s_axi_bready <= 1'b1;
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  // Load a time while stopped, run one second, stop and compare
  task automatic step(input int n);
    logic [31:0] s;
    int k;
    wr(OFS_CTRL, 32'h0000_0000);
    for (k = 0; k < 6; k++) wr(8'(4 * k), {24'h00_0000, tt[n][8*k+:8]});
    wr(OFS_TC_LAST, 32'h0000_0006);
    wr(OFS_CTRL, {24'h00_0000, cc[n]});
    s = {24'h00_0000, tt[n][7:0]};
    k = 0;
    while (s === {24'h00_0000, tt[n][7:0]} && k < 40) begin
      rd(8'h00, s);
      k++;
    end
    rdc(OFS_CTRL, {24'h00_0000, cc[n] & 8'hFD});
    wr(OFS_CTRL, 32'h0000_0000);
    for (k = 0; k < 6; k++) rdc(8'(4 * k), {24'h00_0000, ee[n][8*k+:8]});
    rdc(OFS_TC_LAST, {24'h00_0000, ww[n]});
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    rdc(8'h00, 32'h0000_0000);
    rdc(8'h0C, {24'h00_0000, DAY_RST});
    rdc(OFS_CTRL, {27'h000_0000, CTRL_RST});
    rdc(8'h1C, 32'h0000_0000);
    chk({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR});
    wr(8'h1C, 32'h0000_0005);
    chk({30'h0000_0000, resp}, {30'h0000_0000, RESP_SLVERR});
    // Calendar, wrap, rounding and meridiem cases
    // Daily tick on: four of the cases roll the day over
    wr(OFS_IRQC, 32'h0000_0007);
    for (i = 0; i < 8; i++) step(i);
    chk(np, 4);
    // Alarm and minute tick on the leap-day rollover
    for (i = 0; i < 6; i++) wr(OFS_AL_FIRST + 8'(4 * i), {24'h00_0000, ee[0][8*i+:8]});
    wr(OFS_IRQC, 32'h0000_000D);
    step(0);
    chk(np, 5);
    chk(na, 1);
    // Hourly tick held during sleep, released on wake
    sleep <= 1'b1;
    wr(OFS_IRQC, 32'h0000_001E);
    step(0);
    chk(np, 5);
    chk(na, 2);
    rdc(OFS_STAT, 32'h0000_0002);
    sleep <= 1'b0;
    repeat (3) @(posedge mclk);
    chk(np, 6);
    rdc(OFS_STAT, 32'h0000_0000);
    // Snapshot keeps the old time while live seconds change
    wr(OFS_CTRL, 32'h0000_0008);
    wr(8'h00, 32'h0000_0033);
    rdc(8'h00, {24'h00_0000, ee[0][7:0]});
    rdc(8'h0C, {24'h00_0000, ee[0][31:24]});
    wr(OFS_CTRL, 32'h0000_0000);
    rdc(8'h00, 32'h0000_0033);
    // Second 1 to 2 of the hour shortened by three base strobes
    wr(OFS_IRQC, 32'h0000_0004);
    wr(OFS_COMP, 32'h0000_0003);
    wr(8'h00, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0011);
    while (v !== 32'h0000_0002) rd(8'h00, v);
    // Base strobe every 2 cycles, 8 strobes per second
    chk(tp, 2 * (8 - 3));
    while (v !== 32'h0000_0003) rd(8'h00, v);
    chk(tp, 2 * 8);
    finish_test();
  end
endmodule
